// File: bench/eimp_core_model.sv
`timescale 1ns/1ps
module eimp_core_model
(
  input  wire logic mclk_in,
  input  wire logic irq_request_in,
  output logic      irq_accept_out,
  output logic      irq_return_out
);
  int depth = 0;

  initial
  begin
    irq_accept_out = 1'h0;
    irq_return_out = 1'h0;
  end

  // lingers before taking, so an offered request has to stand while the core is slow
  task automatic take_one(input int delay);
    int n;
    n = 0;
    while (irq_request_in !== 1'h1 && n < 40)
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    for (int i = 0; i < delay; i++)
    begin
      @(posedge mclk_in);
      #1;
    end
    // never accepts a request that has gone away meanwhile
    if (irq_request_in === 1'h1)
    begin
      irq_accept_out = 1'h1;
      @(posedge mclk_in);
      #1;
      irq_accept_out = 1'h0;
      depth++;
    end
  endtask : take_one

  task automatic give_back();
    if (depth > 0)
    begin
      irq_return_out = 1'h1;
      @(posedge mclk_in);
      #1;
      irq_return_out = 1'h0;
      depth--;
    end
  endtask : give_back
endmodule : eimp_core_model

// File: bench/testbench.sv
`timescale 1ns/1ps
`include "eimp_map.svh"
module testbench;
  typedef struct packed {logic kind; logic [14:0] v;} eimp_note_t;

  logic        mclk_in  = 1'h0;
  logic        reset_in = 1'h1;
  logic [7:0]  addr     = 8'h00;
  logic        wr       = 1'h0;
  logic [7:0]  wdata    = 8'h00;
  logic        rd       = 1'h0;
  logic        glb      = 1'h1;
  logic [10:0] flg      = 11'h000;
  logic        probe    = 1'h0;
  logic        rd_q     = 1'h0;
  logic [7:0]  mask_m   = 8'h00;
  logic [15:0] rnd      = 16'hC75D;
  logic [7:0]  rdata;
  logic [7:0]  pend_o;
  logic        req_o;
  logic        lvl_o;
  logic [2:0]  src_o;
  logic [1:0]  svc_o;
  logic        acc;
  logic        ret;
  int          fails    = 0;
  int          checks   = 0;
  int          b;
  int          bit_of[11] = '{0, 1, 2, 3, 4, 5, 5, 6, 6, 7, 7};
  eimp_note_t  notes[$];

  always #2.5 mclk_in = ~mclk_in;

  eimp_top i_dut
  (
    .mclk_in                      (mclk_in),
    .reset_in                     (reset_in),
    .sfr_addr_in                  (addr),
    .sfr_wr_in                    (wr),
    .sfr_wdata_in                 (wdata),
    .sfr_rd_in                    (rd),
    .sfr_rdata_out                (rdata),
    .global_irq_enable_in         (glb),
    .two_wire_irq_in              (flg[0]),
    .port_match_irq_in            (flg[1]),
    .window_compare_flag_in       (flg[2]),
    .conversion_done_flag_in      (flg[3]),
    .counter_array_irq_in         (flg[4]),
    .comparator_a_rising_flag_in  (flg[5]),
    .comparator_a_falling_flag_in (flg[6]),
    .comparator_b_rising_flag_in  (flg[7]),
    .comparator_b_falling_flag_in (flg[8]),
    .timer3_low_overflow_flag_in  (flg[9]),
    .timer3_high_overflow_flag_in (flg[10]),
    .irq_accept_in                (acc),
    .irq_return_in                (ret),
    .irq_request_out              (req_o),
    .irq_level_high_out           (lvl_o),
    .irq_source_out               (src_o),
    .irq_pending_out              (pend_o),
    .in_service_out               (svc_o)
  );

  eimp_core_model i_core
  (
    .mclk_in        (mclk_in),
    .irq_request_in (req_o),
    .irq_accept_out (acc),
    .irq_return_out (ret)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {1'h0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction : lfsr

  function automatic logic [7:0] raw(input logic [10:0] f);
    raw = 8'h00;
    for (int k = 0; k < 11; k++)
      if (f[k]) raw[bit_of[k]] = 1'h1;
  endfunction : raw

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'h1;
    if (a === `EIMP_ADDR_MASK) mask_m = d;
    step(1);
    wr = 1'h0;
    step(1);
  endtask : reg_wr

  // idle cycle after each strobe so no strobe is assigned twice in one time step
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'h1;
    notes.push_back(eimp_note_t'{1'h0, {7'h00, e}});
    step(1);
    rd = 1'h0;
    step(1);
  endtask : reg_rd

  task automatic probe_irq(input logic r, input logic l, input logic [2:0] s, input logic [1:0] v);
    notes.push_back(eimp_note_t'{1'h1, {r, l, s, raw(flg) & mask_m, v}});
    probe = 1'h1;
    step(1);
    probe = 1'h0;
    step(1);
  endtask : probe_irq

  task automatic compare(input logic kind, input logic [14:0] seen);
    eimp_note_t n;
    checks++;
    n = (notes.size() > 0) ? notes.pop_front() : eimp_note_t'{~kind, ~seen};
    if (n.kind !== kind || n.v !== seen)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", kind ? "irq" : "rdata", n.v, seen);
    end
  endtask : compare

  always @(posedge mclk_in)
  begin
    if (rd_q === 1'h1) compare(1'h0, {7'h00, rdata});
    if (probe === 1'h1) compare(1'h1, {req_o, lvl_o, src_o, pend_o, svc_o});
    rd_q <= rd;
  end

  task automatic stop_test();
    if (notes.size() != 0) fails++;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  initial
  begin
    #100000;
    fails++;
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge mclk_in);
    #1;
    reset_in = 1'h0;
    reg_rd(`EIMP_ADDR_MASK, 8'h00);
    reg_rd(`EIMP_ADDR_LEVEL, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      reg_wr(`EIMP_ADDR_MASK, rnd[7:0]);
      reg_wr(`EIMP_ADDR_LEVEL, rnd[15:8]);
      reg_wr(8'hE7, ~rnd[7:0]);
      reg_rd(`EIMP_ADDR_MASK, rnd[7:0]);
      reg_rd(`EIMP_ADDR_LEVEL, rnd[15:8]);
      reg_rd(8'hE7, 8'h00);
    end
    // every flag input alone: blocked by its own mask bit, passed, then gated globally
    for (int k = 0; k < 11; k++)
    begin
      b = bit_of[k];
      rnd = lfsr(rnd);
      reg_wr(`EIMP_ADDR_LEVEL, rnd[7:0]);
      reg_wr(`EIMP_ADDR_MASK, ~(8'h01 << b));
      flg = 11'h001 << k;
      step(1);
      probe_irq(1'h0, 1'h0, 3'h0, 2'h0);
      reg_wr(`EIMP_ADDR_MASK, 8'h01 << b);
      step(1);
      probe_irq(1'h1, rnd[b], b[2:0], 2'h0);
      glb = 1'h0;
      step(1);
      probe_irq(1'h0, 1'h0, 3'h0, 2'h0);
      glb = 1'h1;
      flg = 11'h000;
    end
    reg_wr(`EIMP_ADDR_MASK, 8'hFF);
    reg_wr(`EIMP_ADDR_LEVEL, 8'h80);
    flg = 11'h009;
    step(1);
    probe_irq(1'h1, 1'h0, 3'h0, 2'h0);
    i_core.take_one(2);
    flg = 11'h008;
    step(1);
    probe_irq(1'h0, 1'h0, 3'h0, 2'h1);
    flg = 11'h608;
    step(1);
    probe_irq(1'h1, 1'h1, 3'h7, 2'h1);
    i_core.take_one(0);
    flg = 11'h008;
    step(1);
    probe_irq(1'h0, 1'h0, 3'h0, 2'h3);
    i_core.give_back();
    step(1);
    probe_irq(1'h0, 1'h0, 3'h0, 2'h1);
    i_core.give_back();
    step(1);
    probe_irq(1'h1, 1'h0, 3'h3, 2'h0);
    // raised to high level the same source enters high service, which blocks all
    reg_wr(`EIMP_ADDR_LEVEL, 8'h08);
    step(1);
    probe_irq(1'h1, 1'h1, 3'h3, 2'h0);
    i_core.take_one(0);
    step(1);
    probe_irq(1'h0, 1'h0, 3'h0, 2'h2);
    flg = 11'h608;
    step(1);
    probe_irq(1'h0, 1'h0, 3'h0, 2'h2);
    i_core.give_back();
    step(1);
    probe_irq(1'h1, 1'h1, 3'h3, 2'h0);
    flg = 11'h000;
    step(2);
    stop_test();
  end
endmodule : testbench

// File: core/eimp_arbiter.sv
`timescale 1ns/1ps
module eimp_arbiter
(
  eimp_arb_if.arbiter arb
);
  // lowest bit wins inside one level
  function automatic eimp_pkg::eimp_src_t eimp_first(input eimp_pkg::eimp_vec_t v);
    eimp_pkg::eimp_src_t r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : eimp_first

  eimp_pkg::eimp_vec_t hi_req;
  eimp_pkg::eimp_vec_t lo_req;

  assign hi_req         = arb.req & arb.high;
  assign lo_req         = arb.req & ~arb.high;
  assign arb.any        = |arb.req;
  // a high level candidate always beats any low one
  assign arb.grant_high = |hi_req;
  assign arb.idx        = arb.grant_high ? eimp_first(hi_req) : eimp_first(lo_req);
endmodule : eimp_arbiter

// File: core/eimp_top.sv
`timescale 1ns/1ps
`include "eimp_map.svh"
module eimp_top
(
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_rd_in,
  output logic      [7:0] sfr_rdata_out,
  input  wire logic       global_irq_enable_in,
  input  wire logic       timer3_low_overflow_flag_in,
  input  wire logic       timer3_high_overflow_flag_in,
  input  wire logic       comparator_b_rising_flag_in,
  input  wire logic       comparator_b_falling_flag_in,
  input  wire logic       comparator_a_rising_flag_in,
  input  wire logic       comparator_a_falling_flag_in,
  input  wire logic       counter_array_irq_in,
  input  wire logic       conversion_done_flag_in,
  input  wire logic       window_compare_flag_in,
  input  wire logic       port_match_irq_in,
  input  wire logic       two_wire_irq_in,
  input  wire logic       irq_accept_in,
  input  wire logic       irq_return_in,
  output logic            irq_request_out,
  output logic            irq_level_high_out,
  output logic      [2:0] irq_source_out,
  output logic      [7:0] irq_pending_out,
  output logic      [1:0] in_service_out
);

  eimp_pkg::eimp_vec_t   peripheral_interrupt_mask_one;
  eimp_pkg::eimp_vec_t   peripheral_interrupt_priority_one;
  eimp_pkg::eimp_state_t state;
  eimp_pkg::eimp_state_t next_state;

  wire                   hit_mask;
  wire                   hit_level;
  eimp_pkg::eimp_vec_t   raw_src;
  eimp_pkg::eimp_vec_t   enabled_src;
  eimp_pkg::eimp_vec_t   allow_src;
  eimp_pkg::eimp_vec_t   next_rdata;
  logic                  next_request;

  eimp_arb_if arb ();

  assign hit_mask  = (sfr_addr_in == `EIMP_ADDR_MASK);
  assign hit_level = (sfr_addr_in == `EIMP_ADDR_LEVEL);

  // the peripherals hold their flags until software clears them, so no
  // capture is needed here: a level that drops before service is simply gone
  assign raw_src[`EIMP_BIT_TIMER3] = timer3_low_overflow_flag_in
                                   | timer3_high_overflow_flag_in;
  assign raw_src[`EIMP_BIT_COMP_B] = comparator_b_rising_flag_in
                                   | comparator_b_falling_flag_in;
  assign raw_src[`EIMP_BIT_COMP_A] = comparator_a_rising_flag_in
                                   | comparator_a_falling_flag_in;
  assign raw_src[`EIMP_BIT_COUNTER]    = counter_array_irq_in;
  assign raw_src[`EIMP_BIT_CONV_DONE]  = conversion_done_flag_in;
  assign raw_src[`EIMP_BIT_WINDOW]     = window_compare_flag_in;
  assign raw_src[`EIMP_BIT_PORT_MATCH] = port_match_irq_in;
  assign raw_src[`EIMP_BIT_TWO_WIRE]   = two_wire_irq_in;

  // per source gating by its own mask bit; the global enable is applied later, at arb.req
  wire timer3_irq_mask        = peripheral_interrupt_mask_one[`EIMP_BIT_TIMER3];
  wire comparator_b_irq_mask  = peripheral_interrupt_mask_one[`EIMP_BIT_COMP_B];
  wire comparator_a_irq_mask  = peripheral_interrupt_mask_one[`EIMP_BIT_COMP_A];
  wire counter_array_irq_mask = peripheral_interrupt_mask_one[`EIMP_BIT_COUNTER];
  wire conversion_done_irq_mask = peripheral_interrupt_mask_one[`EIMP_BIT_CONV_DONE];
  wire window_compare_irq_mask  = peripheral_interrupt_mask_one[`EIMP_BIT_WINDOW];
  wire port_match_irq_mask      = peripheral_interrupt_mask_one[`EIMP_BIT_PORT_MATCH];
  wire two_wire_irq_mask        = peripheral_interrupt_mask_one[`EIMP_BIT_TWO_WIRE];

  assign enabled_src[`EIMP_BIT_TIMER3]     = raw_src[`EIMP_BIT_TIMER3]
                                           & timer3_irq_mask;
  assign enabled_src[`EIMP_BIT_COMP_B]     = raw_src[`EIMP_BIT_COMP_B]
                                           & comparator_b_irq_mask;
  assign enabled_src[`EIMP_BIT_COMP_A]     = raw_src[`EIMP_BIT_COMP_A]
                                           & comparator_a_irq_mask;
  assign enabled_src[`EIMP_BIT_COUNTER]    = raw_src[`EIMP_BIT_COUNTER]
                                           & counter_array_irq_mask;
  assign enabled_src[`EIMP_BIT_CONV_DONE]  = raw_src[`EIMP_BIT_CONV_DONE]
                                           & conversion_done_irq_mask;
  assign enabled_src[`EIMP_BIT_WINDOW]     = raw_src[`EIMP_BIT_WINDOW]
                                           & window_compare_irq_mask;
  assign enabled_src[`EIMP_BIT_PORT_MATCH] = raw_src[`EIMP_BIT_PORT_MATCH]
                                           & port_match_irq_mask;
  assign enabled_src[`EIMP_BIT_TWO_WIRE]   = raw_src[`EIMP_BIT_TWO_WIRE]
                                           & two_wire_irq_mask;

  // level of each source, one bit each, high when set
  wire timer3_irq_level          = peripheral_interrupt_priority_one[`EIMP_BIT_TIMER3];
  wire comparator_b_irq_level    = peripheral_interrupt_priority_one[`EIMP_BIT_COMP_B];
  wire comparator_a_irq_level    = peripheral_interrupt_priority_one[`EIMP_BIT_COMP_A];
  wire counter_array_irq_level   = peripheral_interrupt_priority_one[`EIMP_BIT_COUNTER];
  wire conversion_done_irq_level = peripheral_interrupt_priority_one[`EIMP_BIT_CONV_DONE];
  wire window_compare_irq_level  = peripheral_interrupt_priority_one[`EIMP_BIT_WINDOW];
  wire port_match_irq_level      = peripheral_interrupt_priority_one[`EIMP_BIT_PORT_MATCH];
  wire two_wire_irq_level        = peripheral_interrupt_priority_one[`EIMP_BIT_TWO_WIRE];

  assign arb.high[`EIMP_BIT_TIMER3]     = timer3_irq_level;
  assign arb.high[`EIMP_BIT_COMP_B]     = comparator_b_irq_level;
  assign arb.high[`EIMP_BIT_COMP_A]     = comparator_a_irq_level;
  assign arb.high[`EIMP_BIT_COUNTER]    = counter_array_irq_level;
  assign arb.high[`EIMP_BIT_CONV_DONE]  = conversion_done_irq_level;
  assign arb.high[`EIMP_BIT_WINDOW]     = window_compare_irq_level;
  assign arb.high[`EIMP_BIT_PORT_MATCH] = port_match_irq_level;
  assign arb.high[`EIMP_BIT_TWO_WIRE]   = two_wire_irq_level;

  // idle takes any level, low service only high, high service nothing
  assign allow_src = (state == eimp_pkg::EIMP_IDLE)     ? 8'hFF :
                     (state == eimp_pkg::EIMP_SERV_LOW) ? arb.high : 8'h00;

  assign arb.req = enabled_src & allow_src
                 & {8{global_irq_enable_in}};

  eimp_arbiter u_arbiter
  (
    .arb (arb)
  );

  // drop the request while the core takes one, so a stale grant is not
  // taken twice before the service state has moved
  assign next_request = arb.any & ~irq_accept_in;

  assign next_rdata = (sfr_rd_in && hit_mask)  ? peripheral_interrupt_mask_one :
                      (sfr_rd_in && hit_level) ? peripheral_interrupt_priority_one :
                      `EIMP_READ_UNMAPPED;

  always_comb
  begin
    next_state = state;
    case (state)
      eimp_pkg::EIMP_IDLE:
      begin
        if (irq_accept_in)
        begin
          next_state = irq_level_high_out ? eimp_pkg::EIMP_SERV_HIGH
                                          : eimp_pkg::EIMP_SERV_LOW;
        end
      end
      eimp_pkg::EIMP_SERV_LOW:
      begin
        if (irq_return_in)
        begin
          next_state = eimp_pkg::EIMP_IDLE;
        end
        else if (irq_accept_in && irq_level_high_out)
        begin
          next_state = eimp_pkg::EIMP_SERV_PREEMPT;
        end
      end
      eimp_pkg::EIMP_SERV_PREEMPT:
      begin
        if (irq_return_in)
        begin
          next_state = eimp_pkg::EIMP_SERV_LOW;
        end
      end
      eimp_pkg::EIMP_SERV_HIGH:
      begin
        if (irq_return_in)
        begin
          next_state = eimp_pkg::EIMP_IDLE;
        end
      end
      default:
      begin
        next_state = eimp_pkg::EIMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      peripheral_interrupt_mask_one     <= `EIMP_RESET_MASK;
      peripheral_interrupt_priority_one <= `EIMP_RESET_LEVEL;
    end
    else
    begin
      if (sfr_wr_in && hit_mask)
      begin
        peripheral_interrupt_mask_one <= sfr_wdata_in;
      end
      if (sfr_wr_in && hit_level)
      begin
        peripheral_interrupt_priority_one <= sfr_wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state              <= eimp_pkg::EIMP_IDLE;
      sfr_rdata_out      <= `EIMP_READ_UNMAPPED;
      irq_request_out    <= 1'b0;
      irq_level_high_out <= 1'b0;
      irq_source_out     <= 3'h0;
      irq_pending_out    <= 8'h00;
    end
    else
    begin
      state              <= next_state;
      sfr_rdata_out      <= next_rdata;
      irq_request_out    <= next_request;
      irq_level_high_out <= arb.grant_high & next_request;
      irq_source_out     <= arb.idx;
      irq_pending_out    <= enabled_src;
    end
  end

  assign in_service_out = {(state == eimp_pkg::EIMP_SERV_HIGH)
                           || (state == eimp_pkg::EIMP_SERV_PREEMPT),
                           (state == eimp_pkg::EIMP_SERV_LOW)
                           || (state == eimp_pkg::EIMP_SERV_PREEMPT)};

  default clocking chk_clk @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  chk_timer3_masked: assert property (
    irq_request_out && irq_source_out == `EIMP_BIT_TIMER3
    |-> $past(peripheral_interrupt_mask_one[7]) && $past(raw_src[7]))
    else $error("timer 3 request passed while masked");

  chk_comp_b_masked: assert property (
    $past(!peripheral_interrupt_mask_one[6])
    |-> !(irq_request_out && irq_source_out == `EIMP_BIT_COMP_B))
    else $error("comparator b request passed while masked");

  chk_comp_a_passes: assert property (
    state == eimp_pkg::EIMP_IDLE && global_irq_enable_in && !irq_accept_in
    && raw_src == 8'h20 && peripheral_interrupt_mask_one[5]
    |=> irq_request_out && irq_source_out == `EIMP_BIT_COMP_A)
    else $error("enabled comparator a request not forwarded");

  // the index is the source offered now, the mask and flags those one cycle before
  chk_masked_sources: assert property (
    irq_request_out
    |-> |($past(peripheral_interrupt_mask_one & raw_src) & (8'h01 << irq_source_out)))
    else $error("forwarded source was masked or idle");

  chk_level_follows: assert property (
    irq_request_out
    |-> irq_level_high_out
        == |($past(peripheral_interrupt_priority_one) & (8'h01 << irq_source_out)))
    else $error("request level does not match its level bit");

  chk_global_gate: assert property (
    !global_irq_enable_in |=> !irq_request_out)
    else $error("request forwarded while global enable low");

  chk_low_serv_high_only: assert property (
    state == eimp_pkg::EIMP_SERV_LOW ##1 irq_request_out |-> irq_level_high_out)
    else $error("low or equal request during low service");

  chk_high_serv_blocks: assert property (
    state == eimp_pkg::EIMP_SERV_HIGH [*2] |-> !irq_request_out)
    else $error("request forwarded during high service");

  chk_preempt_return: assert property (
    state == eimp_pkg::EIMP_SERV_PREEMPT && irq_return_in
    |=> state == eimp_pkg::EIMP_SERV_LOW)
    else $error("preempting service did not return to low service");

  chk_mask_write: assert property (
    sfr_wr_in && hit_mask |=> peripheral_interrupt_mask_one == $past(sfr_wdata_in))
    else $error("mask write not stored");

  chk_level_readback: assert property (
    sfr_rd_in && hit_level |=> sfr_rdata_out == $past(peripheral_interrupt_priority_one))
    else $error("level register not read back");

  chk_high_beats_low: assert property (
    $past(|(arb.req & arb.high)) && irq_request_out |-> irq_level_high_out)
    else $error("low source chosen over pending high");

  cov_preempt: cover property (
    state == eimp_pkg::EIMP_SERV_LOW ##1 state == eimp_pkg::EIMP_SERV_PREEMPT);
  cov_high_direct: cover property (
    state == eimp_pkg::EIMP_IDLE ##1 state == eimp_pkg::EIMP_SERV_HIGH);
  cov_low_return: cover property (
    state == eimp_pkg::EIMP_SERV_LOW ##1 state == eimp_pkg::EIMP_IDLE);
  cov_level_read: cover property (
    sfr_rd_in && hit_level ##1 sfr_rdata_out != 8'h00);

endmodule : eimp_top

// File: shared/eimp_arb_if.sv
`timescale 1ns/1ps
interface eimp_arb_if;
  eimp_pkg::eimp_vec_t req;
  eimp_pkg::eimp_vec_t high;
  logic                any;
  logic                grant_high;
  eimp_pkg::eimp_src_t idx;

  modport requester
  (
    output req,
    output high,
    input  any,
    input  grant_high,
    input  idx
  );

  modport arbiter
  (
    input  req,
    input  high,
    output any,
    output grant_high,
    output idx
  );
endinterface : eimp_arb_if

// File: shared/eimp_map.svh
`ifndef EIMP_MAP_SVH
`define EIMP_MAP_SVH

// special function register addresses
`define EIMP_ADDR_MASK      8'hE6
`define EIMP_ADDR_LEVEL     8'hF3

// reset values
`define EIMP_RESET_MASK     8'h00
`define EIMP_RESET_LEVEL    8'h00
`define EIMP_READ_UNMAPPED  8'h00

// bit positions shared by the mask and level registers
`define EIMP_BIT_TIMER3     3'h7
`define EIMP_BIT_COMP_B     3'h6
`define EIMP_BIT_COMP_A     3'h5
`define EIMP_BIT_COUNTER    3'h4
`define EIMP_BIT_CONV_DONE  3'h3
`define EIMP_BIT_WINDOW     3'h2
`define EIMP_BIT_PORT_MATCH 3'h1
`define EIMP_BIT_TWO_WIRE   3'h0

`endif

// File: shared/eimp_pkg.sv
package eimp_pkg;

  // gray along idle -> low -> low preempted by high -> low -> idle
  typedef enum logic [1:0]
  {
    EIMP_IDLE         = 2'h0,
    EIMP_SERV_LOW     = 2'h1,
    EIMP_SERV_PREEMPT = 2'h3,
    EIMP_SERV_HIGH    = 2'h2
  } eimp_state_t;

  typedef logic [2:0] eimp_src_t;
  typedef logic [7:0] eimp_vec_t;

endpackage : eimp_pkg
